// ---- shared/timer16_defs.vh ----
// Constants for the 16-bit timer/counter core
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// ****************************************
// Register byte offsets on the APB bus
// ****************************************
`define T16_OFS_CTRL_A     12'h000
`define T16_OFS_CTRL_B     12'h004
`define T16_OFS_CNT_LO     12'h008
`define T16_OFS_CNT_HI     12'h00C
`define T16_OFS_CMPA_LO    12'h010
`define T16_OFS_CMPA_HI    12'h014
`define T16_OFS_CMPB_LO    12'h018
`define T16_OFS_CMPB_HI    12'h01C
`define T16_OFS_CAP_LO     12'h020
`define T16_OFS_CAP_HI     12'h024
`define T16_OFS_FLAGS      12'h028
`define T16_OFS_MASK       12'h02C

// ****************************************
// Field positions
// ****************************************
`define T16_A_MODE_LSB     0
`define T16_B_CS_LSB       0
`define T16_B_MODE_LSB     3
`define T16_B_EDGE_BIT     6
`define T16_B_FILT_BIT     7
`define T16_FLG_OVF        0
`define T16_FLG_MA         1
`define T16_FLG_MB         2
`define T16_FLG_CAP        3

// ****************************************
// Reset values and top limits
// ****************************************
`define T16_RST_BYTE       8'h00
`define T16_RST_WORD       16'h0000
`define T16_MAX_VALUE      16'hFFFF
`define T16_TOP_8BIT       16'h00FF
`define T16_TOP_9BIT       16'h01FF
`define T16_TOP_10BIT      16'h03FF

// ****************************************
// Clock select codes, prescaler width and filter depth
// ****************************************
`define T16_CS_STOP        3'h0
`define T16_CS_DIV1        3'h1
`define T16_CS_DIV8        3'h2
`define T16_CS_DIV64       3'h3
`define T16_CS_DIV256      3'h4
`define T16_CS_DIV1024     3'h5
`define T16_CS_EXT_FALL    3'h6
`define T16_CS_EXT_RISE    3'h7
`define T16_PRE_WIDTH      10
`define T16_FILT_DEPTH     4

`endif

// ---- hw/timer16_counter_core.v ----
// 16-bit timer/counter core with APB register access
//
// Operation
// - Sixteen-bit counter clears, increments or decrements.
// - Each timer tick counts according to mode.
// - Clock select zero stops the counter.
// - CPU accesses counter with clock stopped.
// - CPU counter write beats counting.
// - Low read latches high byte; high reads latch.
// - High write fills latch; low write loads all.
// - Counter, compares, capture use latch access.
// - Control registers are plain eight-bit registers.
// - Tick from prescaler or external pin edge.
// - Three-bit clock select in control B.
// - Compares run continuously to match outputs.
// - Compare match sets its match flag.
// - Four flags, each gated by mask bit.
// - Capture edge copies counter to capture register.
// - Top from compare A, capture or fixed.
// - Compare A top double-buffered in PWM.
// - Bottom signalled when counter reaches zero.
// - Four-bit mode split across A and B.
// - Overflow flag set where mode defines.
// - Low two mode bits in A, high two in B.
// - Optional noise filter on capture trigger.
// - Filter passes after four equal samples.
// - Flags clear on acknowledge or written one.
//
// The APB register port and the placing of the registers are this design's own decisions.
`include "timer16_defs.vh"

module timer16_counter_core
(
  input  wire        pclk,               // Bus and timer clock
  input  wire        presetn,            // Async reset, active low
  input  wire        psel,               // APB select
  input  wire        penable,            // APB access phase
  input  wire        pwrite,             // APB write direction
  input  wire [11:0] paddr,              // APB byte address
  input  wire [31:0] pwdata,             // APB write data
  output wire        pready,             // APB ready, always high
  output wire        pslverr,            // APB error on unmapped
  output reg  [31:0] prdata,             // APB read data
  input  wire        external_count_pin, // External count input
  input  wire        capture_input_pin,  // Capture trigger pin
  input  wire        comparator_output,  // Comparator trigger
  input  wire        comparator_select,  // Pick comparator trigger
  input  wire [3:0]  irq_ack,            // Handler taken, per flag
  output wire [3:0]  irq_req,            // Masked flag requests
  output wire        match_a,            // Compare A equal
  output wire        match_b,            // Compare B equal
  output wire        at_top,             // Counter equals top
  output wire        at_bottom,          // Counter is zero
  output wire        count_down,         // Counting down now
  output wire        top_from_cmp_a,     // Compare A used as top in PWM modes 9, B, F
  output wire        timer_tick,         // Timer clock enable
  output wire [15:0] count_value         // Live counter value
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0]  ctrl_a_r;
  reg  [7:0]  ctrl_b_r;
  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg         down_r;
  reg         down_nxt;
  reg  [7:0]  temp_r;
  reg  [15:0] cmp_a_r;
  reg  [15:0] cmp_a_buf_r;
  reg  [15:0] cmp_b_r;
  reg  [15:0] cmp_b_buf_r;
  reg  [15:0] capture_r;
  reg  [3:0]  flags_r;
  reg  [3:0]  mask_r;
  reg  [`T16_PRE_WIDTH-1:0] pre_r;
  reg         ext_prev_r;
  reg  [`T16_FILT_DEPTH-1:0] filt_pipe_r;
  reg         filt_lvl_r;
  reg         trig_prev_r;
  reg         block_r;
  reg         tick;
  reg  [15:0] top;
  reg  [7:0]  rd_byte;
  reg         mapped;

  // Bus decode
  wire        setup   = psel & ~penable;
  wire        access  = psel & penable;
  wire        wr      = access & pwrite;
  wire        rd_set  = setup & ~pwrite;
  wire [7:0]  wbyte   = pwdata[7:0];
  wire        wr_a    = wr & (paddr == `T16_OFS_CTRL_A);
  wire        wr_b    = wr & (paddr == `T16_OFS_CTRL_B);
  wire        wr_cl   = wr & (paddr == `T16_OFS_CNT_LO);
  wire        wr_ma   = wr & (paddr == `T16_OFS_CMPA_LO);
  wire        wr_mb   = wr & (paddr == `T16_OFS_CMPB_LO);
  wire        wr_pl   = wr & (paddr == `T16_OFS_CAP_LO);
  wire        wr_hi   = wr & ((paddr == `T16_OFS_CNT_HI) |
                              (paddr == `T16_OFS_CMPA_HI) |
                              (paddr == `T16_OFS_CMPB_HI) |
                              (paddr == `T16_OFS_CAP_HI));
  wire        wr_flg  = wr & (paddr == `T16_OFS_FLAGS);
  wire        wr_msk  = wr & (paddr == `T16_OFS_MASK);
  wire [15:0] wword   = {temp_r, wbyte};

  // Mode field: low bits in A, high bits in B
  wire [3:0]  mode    = {ctrl_b_r[`T16_B_MODE_LSB+1],
                         ctrl_b_r[`T16_B_MODE_LSB],
                         ctrl_a_r[`T16_A_MODE_LSB+1],
                         ctrl_a_r[`T16_A_MODE_LSB]};
  wire [2:0]  clock_source_select = ctrl_b_r[`T16_B_CS_LSB+2:
                                             `T16_B_CS_LSB];
  wire        edge_rise  = ctrl_b_r[`T16_B_EDGE_BIT];
  wire        filt_en    = ctrl_b_r[`T16_B_FILT_BIT];

  // ****************************************
  // Mode classification and top value
  // ****************************************

  // Dual-slope modes: phase correct and phase-frequency correct
  wire dual   = (mode == 4'h1) | (mode == 4'h2) | (mode == 4'h3) |
                (mode == 4'h8) | (mode == 4'h9) | (mode == 4'hA) |
                (mode == 4'hB);
  // PWM modes buffer the compare registers
  wire pwm    = dual | (mode == 4'h5) | (mode == 4'h6) |
                (mode == 4'h7) | (mode == 4'hE) | (mode == 4'hF);
  // Capture register holds top; capture input then unused
  wire cap_top = (mode == 4'h8) | (mode == 4'hA) | (mode == 4'hC) |
                 (mode == 4'hE);
  // Buffered compares load at bottom in these modes, else at top
  wire upd_bot = (mode == 4'h8) | (mode == 4'h9);
  // Fast modes overflow at top, dual at bottom, others at max
  wire fast   = pwm & ~dual;

  assign top_from_cmp_a = pwm & ((mode == 4'h9) | (mode == 4'hB) |
                                 (mode == 4'hF));

  // Top selection per mode
  always @*
  begin
    case (mode)
      4'h1, 4'h5: top = `T16_TOP_8BIT;
      4'h2, 4'h6: top = `T16_TOP_9BIT;
      4'h3, 4'h7: top = `T16_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top = cmp_a_r;
      4'h8, 4'hA, 4'hC, 4'hE: top = capture_r;
      default:    top = `T16_MAX_VALUE;
    endcase
  end

  // ****************************************
  // Clock select and prescaler
  // ****************************************

  // Free-running prescaler, held clear while stopped
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pre_r <= {`T16_PRE_WIDTH{1'b0}};
    else if (clock_source_select == `T16_CS_STOP)
      pre_r <= {`T16_PRE_WIDTH{1'b0}};
    else
      pre_r <= pre_r + 1'b1;
  end

  // Previous external pin level for edge detection
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_prev_r <= 1'b0;
    else
      ext_prev_r <= external_count_pin;
  end

  // Tick enable per clock select code
  always @*
  begin
    case (clock_source_select)
      `T16_CS_DIV1:     tick = 1'b1;
      `T16_CS_DIV8:     tick = &pre_r[2:0];
      `T16_CS_DIV64:    tick = &pre_r[5:0];
      `T16_CS_DIV256:   tick = &pre_r[7:0];
      `T16_CS_DIV1024:  tick = &pre_r[9:0];
      `T16_CS_EXT_FALL: tick = ext_prev_r & ~external_count_pin;
      `T16_CS_EXT_RISE: tick = ~ext_prev_r & external_count_pin;
      default:          tick = 1'b0;
    endcase
  end

  assign timer_tick = tick;

  // ****************************************
  // Counter unit
  // ****************************************

  // Next count: CPU write first, then tick-driven count
  always @*
  begin
    count_nxt = count_r;
    down_nxt  = down_r;
    if (wr_cl)
    begin
      count_nxt = wword;
    end
    else if (tick)
    begin
      if (dual)
      begin
        if (!down_r && count_r >= top)
        begin
          down_nxt  = 1'b1;
          count_nxt = count_r - 1'b1;
        end
        else if (down_r && count_r == `T16_RST_WORD)
        begin
          down_nxt  = 1'b0;
          count_nxt = count_r + 1'b1;
        end
        else if (down_r)
          count_nxt = count_r - 1'b1;
        else
          count_nxt = count_r + 1'b1;
      end
      else
      begin
        down_nxt = 1'b0;
        if (count_r == top)
          count_nxt = `T16_RST_WORD;
        else
          count_nxt = count_r + 1'b1;
      end
    end
  end

  // Counter and direction state
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_r <= `T16_RST_WORD;
      down_r  <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      down_r  <= down_nxt;
    end
  end

  // Counter write blocks compare match on the next tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_r <= 1'b0;
    else if (wr_cl)
      block_r <= 1'b1;
    else if (tick)
      block_r <= 1'b0;
  end

  assign count_value = count_r;
  assign count_down  = down_r;
  assign at_bottom   = (count_r == `T16_RST_WORD);
  assign at_top      = (count_r == top);

  // ****************************************
  // Compare units
  // ****************************************

  assign match_a = (count_r == cmp_a_r);
  assign match_b = (count_r == cmp_b_r);

  // Buffered compares load at top or bottom in PWM modes
  wire cmp_load = tick & (upd_bot ? at_bottom : at_top);

  // Buffer and active compare values
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_a_buf_r <= `T16_RST_WORD;
      cmp_b_buf_r <= `T16_RST_WORD;
      cmp_a_r     <= `T16_RST_WORD;
      cmp_b_r     <= `T16_RST_WORD;
    end
    else
    begin
      if (wr_ma)
        cmp_a_buf_r <= wword;
      if (wr_mb)
        cmp_b_buf_r <= wword;
      if (!pwm)
      begin
        cmp_a_r <= wr_ma ? wword : cmp_a_buf_r;
        cmp_b_r <= wr_mb ? wword : cmp_b_buf_r;
      end
      else if (cmp_load)
      begin
        cmp_a_r <= cmp_a_buf_r;
        cmp_b_r <= cmp_b_buf_r;
      end
    end
  end

  // ****************************************
  // Capture unit
  // ****************************************

  wire trig_raw = comparator_select ? comparator_output :
                  capture_input_pin;

  // Four-deep sample pipeline; level moves when all agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_pipe_r <= {`T16_FILT_DEPTH{1'b0}};
      filt_lvl_r  <= 1'b0;
    end
    else
    begin
      filt_pipe_r <= {filt_pipe_r[`T16_FILT_DEPTH-2:0], trig_raw};
      if (&filt_pipe_r)
        filt_lvl_r <= 1'b1;
      else if (~|filt_pipe_r)
        filt_lvl_r <= 1'b0;
    end
  end

  wire trig_lvl = filt_en ? filt_lvl_r : trig_raw;

  // Edge detector history
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trig_prev_r <= 1'b0;
    else
      trig_prev_r <= trig_lvl;
  end

  wire cap_evt = ~cap_top & (trig_prev_r != trig_lvl) &
                 (trig_lvl == edge_rise);

  // Capture register: counter snapshot, or top write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      capture_r <= `T16_RST_WORD;
    else if (cap_evt)
      capture_r <= count_r;
    else if (wr_pl && cap_top)
      capture_r <= wword;
  end

  // ****************************************
  // Flags and masks
  // ****************************************

  wire ovf_set = tick & (dual ? (down_r & count_r == 16'h0001) :
                 fast ? at_top :
                 (count_r == `T16_MAX_VALUE));
  wire ma_set  = tick & match_a & ~block_r;
  wire mb_set  = tick & match_b & ~block_r;
  wire [3:0] flg_set = {cap_evt, mb_set, ma_set, ovf_set};
  wire [3:0] flg_clr = irq_ack | (wr_flg ? wbyte[3:0] : 4'h0);

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_r <= 4'h0;
    else
      flags_r <= flg_set | (flags_r & ~flg_clr);
  end

  assign irq_req = flags_r & mask_r;

  // ****************************************
  // Control, mask and high-byte latch
  // ****************************************

  // Plain control and mask registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_a_r <= `T16_RST_BYTE;
      ctrl_b_r <= `T16_RST_BYTE;
      mask_r   <= 4'h0;
    end
    else
    begin
      if (wr_a)
        ctrl_a_r <= wbyte;
      if (wr_b)
        ctrl_b_r <= wbyte;
      if (wr_msk)
        mask_r <= wbyte[3:0];
    end
  end

  // Low-byte reads and high-byte writes feed the latch
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      temp_r <= `T16_RST_BYTE;
    else if (wr_hi)
      temp_r <= wbyte;
    else if (rd_set)
    begin
      case (paddr)
        `T16_OFS_CNT_LO:  temp_r <= count_r[15:8];
        `T16_OFS_CMPA_LO: temp_r <= cmp_a_buf_r[15:8];
        `T16_OFS_CMPB_LO: temp_r <= cmp_b_buf_r[15:8];
        `T16_OFS_CAP_LO:  temp_r <= capture_r[15:8];
        default:          temp_r <= temp_r;
      endcase
    end
  end

  // ****************************************
  // APB read path
  // ****************************************

  // Read mux; high locations return the latch
  always @*
  begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (paddr)
      `T16_OFS_CTRL_A:  rd_byte = ctrl_a_r;
      `T16_OFS_CTRL_B:  rd_byte = ctrl_b_r;
      `T16_OFS_CNT_LO:  rd_byte = count_r[7:0];
      `T16_OFS_CMPA_LO: rd_byte = cmp_a_buf_r[7:0];
      `T16_OFS_CMPB_LO: rd_byte = cmp_b_buf_r[7:0];
      `T16_OFS_CAP_LO:  rd_byte = capture_r[7:0];
      `T16_OFS_CNT_HI,
      `T16_OFS_CMPA_HI,
      `T16_OFS_CMPB_HI,
      `T16_OFS_CAP_HI:  rd_byte = temp_r;
      `T16_OFS_FLAGS:   rd_byte = {4'h0, flags_r};
      `T16_OFS_MASK:    rd_byte = {4'h0, mask_r};
      default:          mapped  = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_set)
      prdata <= {24'h000000, rd_byte};
  end

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

endmodule

// ---- bench/timer16_core_monitor.sv ----
// Port-level assertion checker for the 16-bit timer core
`include "timer16_defs.vh"

module timer16_core_monitor
(
  input wire logic        pclk,        // Clock
  input wire logic        presetn,     // Async reset, active low
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB access phase
  input wire logic        pwrite,      // APB direction
  input wire logic [11:0] paddr,       // APB address
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic [31:0] prdata,      // APB read data
  input wire logic [3:0]  irq_ack,     // Flag acknowledge
  input wire logic [3:0]  irq_req,     // Masked requests
  input wire logic        match_a,     // Compare A equal
  input wire logic        at_bottom,   // Counter is zero
  input wire logic        timer_tick,  // Timer clock enable
  input wire logic [15:0] count_value  // Live counter
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Write access qualifier and written low byte
  logic       wr_acc;
  logic [7:0] wr_lo;
  assign wr_acc = psel && penable && pwrite;
  assign wr_lo  = pwdata[7:0];

  bottom_flag_a: assert property (
    at_bottom == (count_value == 16'h0000))
    else $error("bottom flag disagrees with counter");
  count_hold_a: assert property (
    !timer_tick && !wr_acc |=> $stable(count_value))
    else $error("counter moved without tick or write");
  count_step_a: assert property (
    timer_tick && !wr_acc |=> count_value == 16'h0000 ||
    (count_value - $past(count_value)) inside {16'h0001, 16'hFFFF})
    else $error("counter step not clear, up or down by one");
  write_wins_a: assert property (
    wr_acc && paddr == `T16_OFS_CNT_LO |=> count_value[7:0] == $past(wr_lo))
    else $error("counter low write lost");
  rdata_width_a: assert property (
    prdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  ovf_rise_a: assert property (
    $rose(irq_req[0]) |-> $past(timer_tick) || $past(wr_acc))
    else $error("overflow request without tick");
  match_rise_a: assert property (
    $rose(irq_req[1]) |-> $past(timer_tick && match_a) || $past(wr_acc))
    else $error("match A request without match at tick");
  ack_clear_a: assert property (
    irq_ack[1] && !timer_tick && !wr_acc |=> !irq_req[1])
    else $error("acknowledge did not clear match A");

  // Main scenarios reached
  wrap_c: cover property (timer_tick && count_value == 16'hFFFF);
  ack_c: cover property (irq_ack[1]);
  capture_c: cover property ($rose(irq_req[3]));
endmodule

bind timer16_counter_core timer16_core_monitor mon
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .irq_ack, .irq_req, .match_a, .at_bottom, .timer_tick, .count_value
);

// ---- bench/cpu_bus_model.sv ----
// CPU side model: APB master and interrupt acknowledge pulses
module cpu_bus_model
(
  input  wire logic        pclk,     // Bus clock
  input  wire logic        pready,   // Slave ready
  input  wire logic        pslverr,  // Slave error
  input  wire logic [31:0] prdata,   // Read data
  output logic             psel,     // Select
  output logic             penable,  // Access phase
  output logic             pwrite,   // Direction
  output logic      [11:0] paddr,    // Byte address
  output logic      [31:0] pwdata,   // Write data
  output logic       [3:0] irq_ack   // Handler taken pulses
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    irq_ack = 4'h0;
  end

  // Setup, access held until ready, then release with data scrambled
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask

  // Interrupt taken: one-cycle acknowledge
  task automatic ack(input logic [3:0] m);
    @(posedge pclk);
    irq_ack <= m;
    @(posedge pclk);
    irq_ack <= 4'h0;
  endtask
endmodule

// ---- bench/timer16_counter_core_tb.sv ----
// Self-checking testbench for the 16-bit timer core
`include "timer16_defs.vh"
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin \
  error_cnt++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); \
  end end

module timer16_counter_core_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, psel, penable, pwrite, pready, pslverr;
  logic        presetn = 1'b0, external_count_pin = 1'b0;
  logic        capture_input_pin = 1'b0, comparator_output = 1'b0;
  logic        comparator_select = 1'b0;
  logic        match_a, match_b, at_top, at_bottom, count_down;
  logic        top_from_cmp_a, timer_tick, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  irq_ack, irq_req;
  logic [15:0] count_value, v;
  logic [7:0]  q;
  int          error_cnt = 0, total_checks = 0, seed = 45, n;

  timer16_counter_core dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .prdata, .external_count_pin,
    .capture_input_pin, .comparator_output, .comparator_select, .irq_ack,
    .irq_req, .match_a, .match_b, .at_top, .at_bottom, .count_down,
    .top_from_cmp_a, .timer_tick, .count_value);
  cpu_bus_model cpu (.pclk, .pready, .pslverr, .prdata, .psel, .penable,
    .pwrite, .paddr, .pwdata, .irq_ack);

  // Clock and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    #(30000 * 100);
    error_cnt++;
    report_and_stop;
  end

  // Counts, verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register access helpers, 16-bit pairs in latch order
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       y;
    cpu.xfer(1'b1, a, d, x, y);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    logic y;
    cpu.xfer(1'b0, a, 8'h00, d, y);
  endtask
  task automatic wr16(input logic [11:0] a, input logic [15:0] d);
    wr(a + 12'h004, d[15:8]);
    wr(a, d[7:0]);
  endtask
  task automatic rd16(input logic [11:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 12'h004, d[15:8]);
  endtask

  // Settle past an edge; bounded wait for a request
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask
  task automatic wait_irq(input int b);
    int k;
    k = 0;
    #1;
    while (irq_req[b] !== 1'b1 && k < 64)
    begin
      cyc(1);
      k++;
    end
  endtask

  // Drive the selected capture source, then wait
  task automatic trig(input int s, input logic l, input int k);
    @(posedge pclk);
    if (s == 1)
      comparator_output <= l;
    else
      capture_input_pin <= l;
    repeat (k) @(posedge pclk);
  endtask

  // Ticks expected in 2048 cycles with 8 pin toggles
  function automatic int exp_ticks(input int cs);
    case (cs)
      1: return 2048;
      2: return 256;
      3: return 32;
      4: return 8;
      5: return 2;
      6, 7: return 4;
      default: return 0;
    endcase
  endfunction

  // Test sequence
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 48; a += 4)
    begin
      rd(a[11:0], q);
      `CHK(q, 8'h00)
    end
    cpu.xfer(1'b0, 12'h030, 8'h00, q, e);
    `CHK({e, q}, 9'h100)
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr(`T16_OFS_CTRL_A, r[7:0] & 8'h03);
      wr(`T16_OFS_CTRL_B, r[15:8] & 8'hD8);
      rd(`T16_OFS_CTRL_A, q);
      `CHK(q, r[7:0] & 8'h03)
      rd(`T16_OFS_CTRL_B, q);
      `CHK(q, r[15:8] & 8'hD8)
    end
    wr(`T16_OFS_CTRL_A, 8'h00);
    wr(`T16_OFS_CTRL_B, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = $random(seed);
      wr16(`T16_OFS_CNT_LO, r[15:0]);
      cyc(3);
      `CHK(count_value, r[15:0])
      rd16(`T16_OFS_CNT_LO, v);
      `CHK(v, r[15:0])
      wr(`T16_OFS_CNT_LO, r[23:16]);
      cyc(1);
      `CHK(count_value, {r[15:8], r[23:16]})
    end
    wr(`T16_OFS_CTRL_B, 8'h01);
    r = $random(seed);
    wr16(`T16_OFS_CNT_LO, r[15:0]);
    #1;
    `CHK(count_value, r[15:0])
    cyc(1);
    `CHK(count_value, r[15:0] + 16'h0001)
    $display("counter access test done");
    for (int cs = 0; cs < 8; cs++)
    begin
      wr(`T16_OFS_CTRL_B, cs[7:0]);
      #1;
      v = count_value;
      n = 0;
      for (int i = 0; i < 2048; i++)
      begin
        if (timer_tick === 1'b1)
          n++;
        @(posedge pclk);
        if (i % 256 == 0)
          external_count_pin <= ~external_count_pin;
        #1;
      end
      `CHK(n, exp_ticks(cs))
      `CHK(count_value - v, n[15:0])
    end
    $display("clock select test done");
    for (int ch = 0; ch < 2; ch++)
    begin
      wr(`T16_OFS_CTRL_B, 8'h00);
      r = $random(seed);
      v = {2'b01, r[13:0]};
      wr16(ch ? `T16_OFS_CMPB_LO : `T16_OFS_CMPA_LO, v);
      wr16(`T16_OFS_CNT_LO, v - 16'h0003);
      wr(`T16_OFS_FLAGS, 8'h0F);
      wr(`T16_OFS_MASK, 8'h02 << ch);
      wr(`T16_OFS_CTRL_B, 8'h01);
      wait_irq(ch + 1);
      `CHK(count_value, v + 16'h0001)
      wr(`T16_OFS_CTRL_B, 8'h00);
      wr(`T16_OFS_MASK, 8'h00);
      #1;
      `CHK(irq_req, 4'h0)
      rd(`T16_OFS_FLAGS, q);
      `CHK(q[ch + 1], 1'b1)
      wr(`T16_OFS_MASK, 8'h02 << ch);
      if (ch == 0)
        cpu.ack(4'h2);
      else
        wr(`T16_OFS_FLAGS, 8'h04);
      rd(`T16_OFS_FLAGS, q);
      `CHK(q[ch + 1], 1'b0)
    end
    wr16(`T16_OFS_CNT_LO, 16'hFFFD);
    wr(`T16_OFS_FLAGS, 8'h0F);
    wr(`T16_OFS_MASK, 8'h01);
    wr(`T16_OFS_CTRL_B, 8'h01);
    wait_irq(0);
    `CHK(count_value, 16'h0000)
    wr(`T16_OFS_CTRL_B, 8'h00);
    cpu.ack(4'h1);
    #1;
    `CHK(irq_req, 4'h0)
    // Mode 15 uses compare A as top; mode 1 is 8-bit dual slope
    wr(`T16_OFS_CTRL_A, 8'h03);
    wr(`T16_OFS_CTRL_B, 8'h18);
    #1;
    `CHK(top_from_cmp_a, 1'b1)
    wr(`T16_OFS_CTRL_A, 8'h01);
    wr16(`T16_OFS_CNT_LO, 16'h00FE);
    wr(`T16_OFS_MASK, 8'h01);
    wr(`T16_OFS_CTRL_B, 8'h01);
    cyc(1);
    `CHK(at_top, 1'b1)
    cyc(1);
    `CHK({count_down, count_value}, 17'h100FE)
    wr16(`T16_OFS_CNT_LO, 16'h0002);
    wait_irq(0);
    `CHK(count_value, 16'h0000)
    wr(`T16_OFS_CTRL_B, 8'h00);
    $display("flag test done");
    for (int s = 0; s < 2; s++)
    begin
      comparator_select <= s[0];
      wr(`T16_OFS_CTRL_B, 8'h40);
      r = $random(seed);
      wr16(`T16_OFS_CNT_LO, r[15:0]);
      wr(`T16_OFS_FLAGS, 8'h0F);
      trig(s, 1'b1, 8);
      rd16(`T16_OFS_CAP_LO, v);
      `CHK(v, r[15:0])
      rd(`T16_OFS_FLAGS, q);
      `CHK(q[3], 1'b1)
      trig(s, 1'b0, 8);
      wr(`T16_OFS_CTRL_B, 8'hC0);
      wr16(`T16_OFS_CNT_LO, r[31:16]);
      wr(`T16_OFS_FLAGS, 8'h0F);
      trig(s, 1'b1, 2);
      trig(s, 1'b0, 12);
      rd(`T16_OFS_FLAGS, q);
      `CHK(q[3], 1'b0)
      trig(s, 1'b1, 12);
      rd16(`T16_OFS_CAP_LO, v);
      `CHK(v, r[31:16])
      trig(s, 1'b0, 8);
    end
    $display("capture test done");
    report_and_stop;
  end
endmodule
